// ### rip_pkg.sv
// Purpose: shared constants for the clock location access port
// Assumes: Avalon-MM slave with 32-bit byte addresses and 32-bit data
// Notes: the location space is time/date registers followed by user ram
`default_nettype none
package rip_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [31:0] LOC_SELECT_OFFS = 32'h1080_0000;
   localparam logic [31:0] LOC_CONTENTS_OFFS = 32'h1170_0000;
   localparam logic [7:0] LOC_SELECT_RESET = 8'h00;
   // ****************************************************************
   // location space
   // ****************************************************************
   localparam int BYTE_W = 8;
   localparam int LOC_W = 7;
   localparam int LOC_COUNT = 128;
   localparam int TIME_LOC_COUNT = 14;
   localparam int USER_RAM_COUNT = 114;
   localparam int TK_LOC_W = 4;
   localparam logic [LOC_W-1:0] TIME_LOC_LIMIT = 7'h0e;
   localparam logic [TK_LOC_W-1:0] TK_LOC_LIMIT = 4'he;
endpackage
`default_nettype wire

// ### rip_loc_if.sv
// Purpose: carries location accesses from the bus port to the store
// Assumes: one clock shared by both ends
// Notes: read data returns one cycle after rd
`timescale 1ns/10ps
`default_nettype none
interface rip_loc_if;
   logic rd;
   logic wr;
   logic [rip_pkg::LOC_W-1:0] loc;
   logic [rip_pkg::BYTE_W-1:0] wdata;
   logic [rip_pkg::BYTE_W-1:0] rdata;
   modport port_end
   (
      output rd,
      output wr,
      output loc,
      output wdata,
      input rdata
   );
   modport store_end
   (
      input rd,
      input wr,
      input loc,
      input wdata,
      output rdata
   );
endinterface
`default_nettype wire

// ### rip_loc_store.sv
// Purpose: the 128-byte location space of the clock chip
// Assumes: synchronous reset-free array, registered read
// Notes: software writes win over timekeeper updates in the same cycle
`timescale 1ns/10ps
`default_nettype none
module rip_loc_store
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_sync_b,
   // software side
   rip_loc_if.store_end acc,
   // timekeeper update of time and date locations
   input wire logic tk_valid,
   input wire logic [rip_pkg::TK_LOC_W-1:0] tk_loc,
   input wire logic [rip_pkg::BYTE_W-1:0] tk_data
);
   logic [rip_pkg::BYTE_W-1:0] mem_q [0:rip_pkg::LOC_COUNT-1];
   logic [rip_pkg::BYTE_W-1:0] rdata_q;
   logic tk_ok;

   // timekeeper may only touch the time and date block
   assign tk_ok = tk_valid && (tk_loc < rip_pkg::TK_LOC_LIMIT);

   // ****************************************************************
   // storage
   // ****************************************************************
   always_ff @(posedge clk)
   begin
      if (tk_ok)
      begin
         mem_q[{3'h0, tk_loc}] <= tk_data;
      end
      if (acc.wr)
      begin
         mem_q[acc.loc] <= acc.wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         rdata_q <= 8'h00;
      end
      else if (acc.rd)
      begin
         rdata_q <= mem_q[acc.loc];
      end
   end

   assign acc.rdata = rdata_q;
endmodule
`default_nettype wire

// ### rip_top.sv
// Purpose: indexed access port to the clock chip and its user ram
// Assumes: Avalon-MM slave, single clock, bus-side timekeeper on same clock
// Notes: reads take three edges, writes complete in the request cycle
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rip_top
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // avalon-mm slave
   input wire logic [31:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // timekeeper update into time and date locations
   input wire logic tk_valid,
   input wire logic [rip_pkg::TK_LOC_W-1:0] tk_loc,
   input wire logic [rip_pkg::BYTE_W-1:0] tk_data,
   // notice of software writes into time and date locations
   output logic time_wr,
   output logic [rip_pkg::TK_LOC_W-1:0] time_wr_loc,
   output logic [rip_pkg::BYTE_W-1:0] time_wr_data
);
   // ****************************************************************
   // reset release
   // ****************************************************************
   logic rst_meta_q;
   logic rst_sync_b;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_b <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_b <= rst_meta_q;
      end
   end

   // ****************************************************************
   // address decode
   // ****************************************************************
   logic hit_select;
   logic hit_contents;
   logic lane0;
   logic sel_wr;
   logic cont_wr;
   logic cont_rd;

   assign hit_select = (avs_address == rip_pkg::LOC_SELECT_OFFS);
   assign hit_contents = (avs_address == rip_pkg::LOC_CONTENTS_OFFS);
   // only the low byte lane carries register data
   assign lane0 = avs_byteenable[0];
   assign sel_wr = avs_write && hit_select && lane0;
   assign cont_wr = avs_write && hit_contents && lane0;
   assign cont_rd = avs_read && hit_contents;

   // ****************************************************************
   // location select register
   // ****************************************************************
   logic [rip_pkg::BYTE_W-1:0] select_q;

   always_ff @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         select_q <= rip_pkg::LOC_SELECT_RESET;
      end
      else if (sel_wr)
      begin
         // held until the next select write
         select_q <= avs_writedata[7:0];
      end
   end

   // ****************************************************************
   // read sequencing
   // ****************************************************************
   typedef enum logic [2:0]
   {
      RD_IDLE = 3'h1,
      RD_FETCH = 3'h2,
      RD_ANSWER = 3'h4
   } rip_rd_state_t;

   rip_rd_state_t rd_state_q;
   rip_rd_state_t rd_state_d;
   logic rd_issue;
   logic rd_fetch;
   logic rd_answer;

   // one store read per bus read, then one answer cycle
   always_comb
   begin
      rd_state_d = rd_state_q;
      case (rd_state_q)
         RD_IDLE:
         begin
            if (cont_rd)
            begin
               rd_state_d = RD_FETCH;
            end
         end
         RD_FETCH:
         begin
            rd_state_d = RD_ANSWER;
         end
         RD_ANSWER:
         begin
            rd_state_d = RD_IDLE;
         end
         default:
         begin
            rd_state_d = RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         rd_state_q <= RD_IDLE;
      end
      else
      begin
         rd_state_q <= rd_state_d;
      end
   end

   assign rd_issue = cont_rd && (rd_state_q == RD_IDLE);
   assign rd_fetch = (rd_state_q == RD_FETCH);
   assign rd_answer = (rd_state_q == RD_ANSWER);

   // reads of the contents register stall until the byte is ready
   assign avs_waitrequest = cont_rd && !rd_answer;

   // ****************************************************************
   // store access
   // ****************************************************************
   rip_loc_if loc_bus ();

   assign loc_bus.rd = rd_issue;
   assign loc_bus.wr = cont_wr;
   // seven-bit location taken from the latest select write
   assign loc_bus.loc = select_q[rip_pkg::LOC_W-1:0];
   assign loc_bus.wdata = avs_writedata[7:0];

   rip_loc_store u_store
   (
      .clk(clk),
      .rst_sync_b(rst_sync_b),
      .acc(loc_bus.store_end),
      .tk_valid(tk_valid),
      .tk_loc(tk_loc),
      .tk_data(tk_data)
   );

   // ****************************************************************
   // read data
   // ****************************************************************
   logic [31:0] readdata_q;

   always_ff @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         readdata_q <= 32'h0000_0000;
      end
      else if (rd_fetch)
      begin
         // byte in low lane, upper lanes zero
         readdata_q <= {24'h00_0000, loc_bus.rdata};
      end
      else
      begin
         // zero outside the answer cycle, so select and unmapped reads see zero
         readdata_q <= 32'h0000_0000;
      end
   end

   // data straight from the flop, no read mux
   assign avs_readdata = readdata_q;

   // ****************************************************************
   // time and date write notice
   // ****************************************************************
   logic time_hit;
   logic time_wr_q;
   logic [rip_pkg::TK_LOC_W-1:0] time_wr_loc_q;
   logic [rip_pkg::BYTE_W-1:0] time_wr_data_q;

   assign time_hit = cont_wr && (loc_bus.loc < rip_pkg::TIME_LOC_LIMIT);

   always_ff @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         time_wr_q <= 1'b0;
      end
      else
      begin
         time_wr_q <= time_hit;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         time_wr_loc_q <= 4'h0;
         time_wr_data_q <= 8'h00;
      end
      else if (time_hit)
      begin
         time_wr_loc_q <= loc_bus.loc[rip_pkg::TK_LOC_W-1:0];
         time_wr_data_q <= avs_writedata[7:0];
      end
   end

   assign time_wr = time_wr_q;
   assign time_wr_loc = time_wr_loc_q;
   assign time_wr_data = time_wr_data_q;
endmodule
`default_nettype wire

// ### rip_top_asserts.sv
// Purpose: port checks for rip_top
// Assumes: rst_b low resets
// Notes: sel_q mirrors select writes
`timescale 1ns/10ps
`default_nettype none
module rip_top_asserts
(
   // watched ports
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [31:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic time_wr,
   input wire logic [3:0] time_wr_loc,
   input wire logic [7:0] time_wr_data
);
   // ****
   // checks
   // ****
   localparam logic [31:0] S = rip_pkg::LOC_SELECT_OFFS;
   localparam logic [31:0] C = rip_pkg::LOC_CONTENTS_OFFS;
   logic [7:0] sel_q;
   wire logic cw = avs_write && avs_byteenable[0] && avs_address == C;
   wire logic time_sel = sel_q[6:0] < rip_pkg::TIME_LOC_LIMIT;

   // mirror of the location select register
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sel_q <= 8'h00;
      end
      else if (avs_write && avs_byteenable[0] && avs_address == S)
      begin
         sel_q <= avs_writedata[7:0];
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence c_rd; $rose(avs_read) && avs_address == C; endsequence
   sequence c_wait; avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest; endsequence
   sequence tw_seen; time_wr && time_wr_loc == sel_q[3:0]
      && time_wr_data == 8'($past(avs_writedata)); endsequence
   sel_wo_a: assert property (avs_read && avs_address == S |-> avs_readdata == 32'h0)
      else $error("select read not zero");
   rd_lat_a: assert property (c_rd |-> c_wait)
      else $error("read wait wrong");
   wr_fast_a: assert property (avs_write |-> !avs_waitrequest)
      else $error("write held");
   rd_byte_a: assert property (avs_read && !avs_waitrequest
      |-> avs_readdata[31:8] == 24'h0) else $error("read data wider than byte");
   tw_note_a: assert property (cw && time_sel |=> tw_seen)
      else $error("time notice wrong");
   ram_quiet_a: assert property (cw && !time_sel |=> !time_wr)
      else $error("ram notice");
endmodule
`default_nettype wire

// ### rip_tk_model.sv
// Purpose: timekeeper beside the port
// Assumes: same clock as the port
// Notes: keeps the last software time write
`timescale 1ns/10ps
`default_nettype none
module rip_tk_model
(
   // notice in
   input wire logic clk,
   input wire logic time_wr,
   input wire logic [3:0] time_wr_loc,
   input wire logic [7:0] time_wr_data,
   // update out
   output logic tk_valid,
   output logic [3:0] tk_loc,
   output logic [7:0] tk_data
);
   // ****
   // model
   // ****
   logic [11:0] note_q = 12'h000;
   initial {tk_valid, tk_loc, tk_data} = 13'h0000;
   always @(posedge clk)
      if (time_wr)
         note_q <= {time_wr_loc, time_wr_data};
   task tick(input logic [3:0] l, input logic [7:0] d);
      @(posedge clk);
      {tk_valid, tk_loc, tk_data} <= {1'b1, l, d};
      @(posedge clk);
      {tk_valid, tk_loc, tk_data} <= {1'b0, ~l, ~d};
   endtask
endmodule
`default_nettype wire

// ### rip_tb.sv
// Purpose: self-checking bench for rip_top
// Assumes: 250 MHz clock
// Notes: checker bound below
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
   // ****
   // bench
   // ****
   localparam logic [31:0] S = rip_pkg::LOC_SELECT_OFFS;
   localparam logic [31:0] C = rip_pkg::LOC_CONTENTS_OFFS;
   logic clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [31:0] avs_address = 32'h0, avs_writedata = 32'h0, avs_readdata, q;
   logic [3:0] avs_byteenable = 4'h0, tk_loc, time_wr_loc;
   logic [7:0] tk_data, time_wr_data;
   logic avs_waitrequest, tk_valid, time_wr;
   int fail_count = 0, checks = 0;
   always #2 clk = ~clk;
   rip_top dut (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .tk_valid, .tk_loc, .tk_data,
      .time_wr, .time_wr_loc, .time_wr_data);
   rip_tk_model tk (.clk, .time_wr, .time_wr_loc, .time_wr_data, .tk_valid, .tk_loc, .tk_data);
   task acc(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
      {avs_write, avs_read, avs_address, avs_writedata, avs_byteenable} <= {w, !w, a, d, be};
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
      begin
         @(posedge clk);
      end
      // taken at this edge, read data stands here
      q = avs_readdata;
      {avs_write, avs_read} <= 2'b00;
      @(posedge clk);
   endtask
   task t_time;
      for (int i = 0; i < 14; i++)
      begin
         acc(1'b1, S, 32'(i), 4'h1);
         acc(1'b1, C, {24'hff_ffff, 8'(i) ^ 8'h5a}, 4'h1);
         acc(1'b0, C, 32'h0, 4'h1);
         `CHK("time", {24'h0, 8'(i) ^ 8'h5a}, q)
         `CHK("notice", {4'(i), 8'(i) ^ 8'h5a}, tk.note_q)
      end
      acc(1'b1, S, 32'h3, 4'h1);
      tk.tick(4'h3, 8'hc3);
      acc(1'b0, C, 32'h0, 4'h1);
      `CHK("tick", 32'hc3, q)
      acc(1'b0, S, 32'h0, 4'h1);
      `CHK("select", 32'h0, q)
   endtask
   task t_ram;
      logic [31:0] locs;
      logic [7:0] l;
      locs = 32'h0e0f_407f;
      for (int k = 0; k < 8; k++)
      begin
         l = locs[8 * (3 - k % 4) +: 8];
         acc(1'b1, S, {24'h0, l}, 4'h1);
         acc(k < 4, C, {24'h0, l ^ 8'ha5}, 4'h1);
         if (k > 3)
         begin
            `CHK("ram", {24'h0, l ^ 8'ha5}, q)
         end
      end
      `CHK("ram notice", 12'hd57, tk.note_q)
      tk.tick(4'hf, 8'h11);
      acc(1'b1, S, 32'h0f, 4'h1);
      acc(1'b0, C, 32'h0, 4'h1);
      `CHK("tick refused", 32'haa, q)
      acc(1'b1, S, 32'h0e, 4'h1);
      acc(1'b0, C, 32'h0, 4'h1);
      `CHK("reselect", 32'hab, q)
      acc(1'b1, C, 32'h77, 4'he);
      acc(1'b1, S + 32'h4, 32'h1, 4'h1);
      acc(1'b0, S + 32'h4, 32'h0, 4'h1);
      `CHK("unmapped", 32'h0, q)
      acc(1'b0, C, 32'h0, 4'h1);
      `CHK("byte enable", 32'hab, q)
   endtask
   task t_reset;
      rst_b <= 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      acc(1'b0, C, 32'h0, 4'h1);
      `CHK("select reset", 32'h5a, q)
   endtask
   task summarize;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      #40000;
      fail_count++;
      summarize;
   end
   initial
   begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      t_time;
      t_ram;
      t_reset;
      summarize;
   end
endmodule
bind rip_top rip_top_asserts chk (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .time_wr,
   .time_wr_loc, .time_wr_data);
`default_nettype wire
